// File: dpi_port.v
// two-wire target port with register file of the buffered-wiper digipot
`timescale 1ns/1ns
`include "dpi_map.vh"
module dpi_port #(
  parameter [3:0] PART_IDENTIFIER = 4'h3,  // arbitrary value
  parameter [1:0] SILICON_REVISION = 2'h1  // arbitrary value
) (
  input wire sys_clk_in,
  input wire rst_in,
  input wire scl_in,
  input wire sda_in,
  input wire address_select_pin_in,
  input wire user_memory_checksum_error_in,
  input wire factory_memory_checksum_error_in,
  input wire memory_operation_active_in,
  output reg sda_out,
  output reg sda_oe_out,
  output reg [7:0] wiper_setting_out,
  output reg [7:0] spare_nonvolatile_byte_one_out,
  output reg [7:0] spare_nonvolatile_byte_two_out,
  output reg [1:0] output_shutdown_select_out,
  output reg reference_enable_out,
  output reg [1:0] output_gain_select_out,
  output reg update_strobe_out,
  output reg memory_recall_trigger_out,
  output reg memory_store_trigger_out,
  output reg soft_reset_out
);
  localparam [2:0] ST_IDLE = 3'b000;
  localparam [2:0] ST_RX = 3'b001;
  localparam [2:0] ST_RXACK = 3'b010;
  localparam [2:0] ST_TX = 3'b011;
  localparam [2:0] ST_TXACK = 3'b100;

  wire [2:0] pin_s;
  dpi_sync #(.WIDTH(3)) u_sync (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .async_in({address_select_pin_in, sda_in, scl_in}),
    .sync_out(pin_s)
  );
  wire scl_s = pin_s[0];
  wire sda_s = pin_s[1];
  wire sel_s = pin_s[2];

  reg scl_p_reg;
  reg sda_p_reg;
  reg [2:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [1:0] byte_idx_reg;
  reg rd_mode_reg;
  reg gc_mode_reg;
  reg gc_pend_reg;
  reg commit_pend_reg;
  reg [7:0] cmd_reg;
  reg cmd_seen_reg;
  reg [7:0] last_wr_reg;
  reg [7:0] upper_data_byte_reg;
  reg [7:0] lower_tx_reg;
  reg tx_upper_reg;
  reg master_ack_reg;
  reg sel_ne_sda_reg;
  reg sel_ne_scl_reg;
  reg sel_seen1_reg;

  wire scl_rise = scl_s & ~scl_p_reg;
  wire scl_fall = ~scl_s & scl_p_reg;
  wire start_det = scl_s & scl_p_reg & sda_p_reg & ~sda_s;
  wire stop_det = scl_s & scl_p_reg & ~sda_p_reg & sda_s;

  // pin tied to SCL tracks clock at both edges, tied to SDA tracks data
  wire [2:0] sel_code = ~sel_ne_scl_reg ? `DPI_SEL_SCL :
                        ~sel_ne_sda_reg ? `DPI_SEL_SDA :
                        sel_seen1_reg ? `DPI_SEL_VDD : `DPI_SEL_GND;
  wire gen_hit = (shift_reg[7:4] == `DPI_ADDR_PREFIX) &&
                 (shift_reg[3:1] == sel_code);
  wire bc_hit = (shift_reg[7:1] == `DPI_ADDR_BCAST) & ~shift_reg[0];
  wire gc_hit = (shift_reg[7:1] == `DPI_ADDR_GCALL) & ~shift_reg[0];
  wire [15:0] wr_word = {upper_data_byte_reg, shift_reg};
  wire [7:0] rd_sel = cmd_seen_reg ? cmd_reg : last_wr_reg;

  reg [15:0] rd_word;
  always @* begin
    rd_word = 16'h0000;
    case (rd_sel)
      `DPI_CMD_STATUS: begin
        rd_word[15] = user_memory_checksum_error_in;
        rd_word[14] = factory_memory_checksum_error_in;
        rd_word[13] = memory_operation_active_in;
        rd_word[5:0] = {PART_IDENTIFIER, SILICON_REVISION};
      end
      `DPI_CMD_SETUP: begin
        rd_word[12:5] = `DPI_SETUP_RSVD;
        rd_word[`DPI_SHDN_HI:`DPI_SHDN_LO] = output_shutdown_select_out;
        rd_word[`DPI_REFEN_BIT] = reference_enable_out;
        rd_word[`DPI_GAIN_HI:`DPI_GAIN_LO] = output_gain_select_out;
      end
      `DPI_CMD_LOCK: rd_word = `DPI_LOCK_READ;
      `DPI_CMD_WIPER:
        rd_word[`DPI_FLD_HI:`DPI_FLD_LO] = wiper_setting_out;
      `DPI_CMD_SPARE1:
        rd_word[`DPI_FLD_HI:`DPI_FLD_LO] = spare_nonvolatile_byte_one_out;
      `DPI_CMD_SPARE2:
        rd_word[`DPI_FLD_HI:`DPI_FLD_LO] = spare_nonvolatile_byte_two_out;
      default: rd_word = 16'h0000;
    endcase
  end

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      scl_p_reg <= 1'b1;
      sda_p_reg <= 1'b1;
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      byte_idx_reg <= 2'h0;
      rd_mode_reg <= 1'b0;
      gc_mode_reg <= 1'b0;
      gc_pend_reg <= 1'b0;
      commit_pend_reg <= 1'b0;
      cmd_reg <= 8'h00;
      cmd_seen_reg <= 1'b0;
      last_wr_reg <= 8'h00;
      upper_data_byte_reg <= 8'h00;
      lower_tx_reg <= 8'h00;
      tx_upper_reg <= 1'b0;
      master_ack_reg <= 1'b0;
      sel_ne_sda_reg <= 1'b0;
      sel_ne_scl_reg <= 1'b0;
      sel_seen1_reg <= 1'b0;
      sda_out <= 1'b0;
      sda_oe_out <= 1'b0;
      wiper_setting_out <= 8'h00;
      spare_nonvolatile_byte_one_out <= 8'h00;
      spare_nonvolatile_byte_two_out <= 8'h00;
      output_shutdown_select_out <= `DPI_SHDN_RST;
      reference_enable_out <= 1'b0;
      output_gain_select_out <= 2'h0;
      update_strobe_out <= 1'b0;
      memory_recall_trigger_out <= 1'b0;
      memory_store_trigger_out <= 1'b0;
      soft_reset_out <= 1'b0;
    end else begin
      scl_p_reg <= scl_s;
      sda_p_reg <= sda_s;
      sda_out <= 1'b0;
      update_strobe_out <= 1'b0;
      memory_recall_trigger_out <= 1'b0;
      memory_store_trigger_out <= 1'b0;
      soft_reset_out <= 1'b0;
      if (soft_reset_out) begin
        // soft reset restores register defaults, bus state is kept
        wiper_setting_out <= 8'h00;
        spare_nonvolatile_byte_one_out <= 8'h00;
        spare_nonvolatile_byte_two_out <= 8'h00;
        output_shutdown_select_out <= `DPI_SHDN_RST;
        reference_enable_out <= 1'b0;
        output_gain_select_out <= 2'h0;
      end
      if (stop_det) begin
        state_reg <= ST_IDLE;
        sda_oe_out <= 1'b0;
        cmd_seen_reg <= 1'b0;
        commit_pend_reg <= 1'b0;
        gc_pend_reg <= 1'b0;
      end else if (start_det) begin
        // a repeated start keeps the command byte for the read that follows
        state_reg <= ST_RX;
        sda_oe_out <= 1'b0;
        bit_cnt_reg <= 4'h0;
        byte_idx_reg <= 2'h0;
        commit_pend_reg <= 1'b0;
        gc_pend_reg <= 1'b0;
        sel_ne_sda_reg <= 1'b0;
        sel_ne_scl_reg <= 1'b0;
        sel_seen1_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_RX: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            // only clock edges are compared, to avoid pin-to-pin skew
            if ((scl_rise | scl_fall) && byte_idx_reg == 2'h0) begin
              if (sel_s != scl_s)
                sel_ne_scl_reg <= 1'b1;
              if (scl_rise && sel_s != sda_s)
                sel_ne_sda_reg <= 1'b1;
              if (sel_s)
                sel_seen1_reg <= 1'b1;
            end
            if (scl_fall && bit_cnt_reg == `DPI_BYTE_BITS) begin
              bit_cnt_reg <= 4'h0;
              state_reg <= ST_RXACK;
              sda_oe_out <= 1'b1;
              case (byte_idx_reg)
                2'h0: begin
                  rd_mode_reg <= shift_reg[0];
                  gc_mode_reg <= gc_hit;
                  if (!(gen_hit | bc_hit | gc_hit)) begin
                    state_reg <= ST_IDLE;
                    sda_oe_out <= 1'b0;
                  end
                end
                2'h1: begin
                  if (gc_mode_reg) begin
                    gc_pend_reg <= (shift_reg == `DPI_GC_RESET_BYTE);
                    if (shift_reg != `DPI_GC_RESET_BYTE) begin
                      state_reg <= ST_IDLE;
                      sda_oe_out <= 1'b0;
                    end
                  end else begin
                    cmd_reg <= shift_reg;
                    cmd_seen_reg <= 1'b1;
                  end
                end
                2'h2: upper_data_byte_reg <= shift_reg;
                default: commit_pend_reg <= 1'b1;
              endcase
            end
          end
          ST_RXACK: begin
            if (scl_rise && gc_pend_reg) begin
              soft_reset_out <= 1'b1;
              gc_pend_reg <= 1'b0;
            end
            if (scl_fall) begin
              sda_oe_out <= 1'b0;
              commit_pend_reg <= 1'b0;
              byte_idx_reg <= (byte_idx_reg == 2'h3) ? 2'h2 :
                              byte_idx_reg + 2'h1;
              state_reg <= ST_RX;
              if (commit_pend_reg) begin
                last_wr_reg <= cmd_reg;
                update_strobe_out <= 1'b1;
                if (cmd_reg == `DPI_CMD_LOCK) begin
                  memory_recall_trigger_out <= wr_word[`DPI_RECALL_BIT];
                  memory_store_trigger_out <= wr_word[`DPI_STORE_BIT];
                  if (wr_word[`DPI_KEY_HI:`DPI_KEY_LO] == `DPI_SWRST_KEY)
                    soft_reset_out <= 1'b1;
                end else if (!memory_operation_active_in) begin
                  case (cmd_reg)
                    `DPI_CMD_WIPER: wiper_setting_out <=
                      wr_word[`DPI_FLD_HI:`DPI_FLD_LO];
                    `DPI_CMD_SPARE1: spare_nonvolatile_byte_one_out <=
                      wr_word[`DPI_FLD_HI:`DPI_FLD_LO];
                    `DPI_CMD_SPARE2: spare_nonvolatile_byte_two_out <=
                      wr_word[`DPI_FLD_HI:`DPI_FLD_LO];
                    `DPI_CMD_SETUP: begin
                      output_shutdown_select_out <=
                        wr_word[`DPI_SHDN_HI:`DPI_SHDN_LO];
                      reference_enable_out <= wr_word[`DPI_REFEN_BIT];
                      output_gain_select_out <=
                        wr_word[`DPI_GAIN_HI:`DPI_GAIN_LO];
                    end
                    default: last_wr_reg <= cmd_reg;
                  endcase
                end
              end
              if (byte_idx_reg == 2'h0 && rd_mode_reg) begin
                // upper byte leaves first; lower byte held for later
                state_reg <= ST_TX;
                shift_reg <= rd_word[15:8];
                lower_tx_reg <= rd_word[7:0];
                tx_upper_reg <= 1'b1;
                sda_oe_out <= ~rd_word[15];
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              if (bit_cnt_reg == `DPI_LAST_TX_BIT) begin
                bit_cnt_reg <= 4'h0;
                sda_oe_out <= 1'b0;
                state_reg <= ST_TXACK;
              end else begin
                shift_reg <= {shift_reg[6:0], 1'b0};
                sda_oe_out <= ~shift_reg[6];
              end
            end
          end
          ST_TXACK: begin
            if (scl_rise)
              master_ack_reg <= ~sda_s;
            if (scl_fall) begin
              if (master_ack_reg) begin
                // a longer read repeats the register's two bytes
                state_reg <= ST_TX;
                tx_upper_reg <= ~tx_upper_reg;
                shift_reg <= tx_upper_reg ? lower_tx_reg : rd_word[15:8];
                sda_oe_out <= tx_upper_reg ? ~lower_tx_reg[7] :
                              ~rd_word[15];
                if (!tx_upper_reg)
                  lower_tx_reg <= rd_word[7:0];
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // dpi_port

// File: dpi_map.vh
// constants for the digipot two-wire target port
`ifndef DPI_MAP_VH
`define DPI_MAP_VH
// address byte
`define DPI_ADDR_PREFIX 4'h9
`define DPI_ADDR_BCAST 7'h47
`define DPI_ADDR_GCALL 7'h00
`define DPI_GC_RESET_BYTE 8'h06
// low address bits chosen by the select pin
`define DPI_SEL_GND 3'h0
`define DPI_SEL_VDD 3'h1
`define DPI_SEL_SDA 3'h2
`define DPI_SEL_SCL 3'h3
// command byte register select
`define DPI_CMD_STATUS 8'hd0
`define DPI_CMD_SETUP 8'hd1
`define DPI_CMD_LOCK 8'hd3
`define DPI_CMD_WIPER 8'h21
`define DPI_CMD_SPARE1 8'h25
`define DPI_CMD_SPARE2 8'h26
// bits per byte before the acknowledge clock
`define DPI_BYTE_BITS 4'h8
`define DPI_LAST_TX_BIT 4'h7
// 8-bit fields in wiper and spare registers
`define DPI_FLD_HI 11
`define DPI_FLD_LO 4
// output_setup fields and fixed values
`define DPI_SHDN_HI 4
`define DPI_SHDN_LO 3
`define DPI_REFEN_BIT 2
`define DPI_GAIN_HI 1
`define DPI_GAIN_LO 0
`define DPI_SHDN_RST 2'h2
`define DPI_SETUP_RSVD 8'h0f
// lock_and_memory_control fields
`define DPI_LOCK_READ 16'h0008
`define DPI_RECALL_BIT 5
`define DPI_STORE_BIT 4
`define DPI_KEY_HI 3
`define DPI_KEY_LO 0
`define DPI_SWRST_KEY 4'ha
`endif

// File: dpi_sync.v
// two flip-flop synchroniser, one lane per bit
`timescale 1ns/1ns
module dpi_sync #(
  parameter WIDTH = 3
) (
  input wire sys_clk_in,
  input wire rst_in,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_lane
      reg meta_reg;
      reg stable_reg;
      // bus idles high, so reset to the idle level
      always @(posedge sys_clk_in) begin
        if (rst_in) begin
          meta_reg <= 1'b1;
          stable_reg <= 1'b1;
        end else begin
          meta_reg <= async_in[i];
          stable_reg <= meta_reg;
        end
      end
      assign sync_out[i] = stable_reg;
    end
  endgenerate
endmodule // dpi_sync

// File: dpi_port_properties.sv
// assertions on the ports of the digipot two-wire target port
`timescale 1ns/1ns
module dpi_port_chk (
  input logic sys_clk_in,
  input logic rst_in,
  input logic scl_in,
  input logic sda_in,
  input logic memory_operation_active_in,
  input logic sda_oe_out,
  input logic [7:0] wiper_setting_out,
  input logic [7:0] spare_nonvolatile_byte_one_out,
  input logic [7:0] spare_nonvolatile_byte_two_out,
  input logic [1:0] output_shutdown_select_out,
  input logic reference_enable_out,
  input logic [1:0] output_gain_select_out,
  input logic update_strobe_out,
  input logic soft_reset_out
);
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  // all stored fields in one word, so one check covers every stored field output
  wire [28:0] regs = {wiper_setting_out, spare_nonvolatile_byte_one_out,
    spare_nonvolatile_byte_two_out, output_shutdown_select_out,
    reference_enable_out, output_gain_select_out};
  localparam logic [28:0] regs_rst = 29'h0000_0010;
  sequence s_stop;
    scl_in && $rose(sda_in);
  endsequence
  sequence s_held;
    sda_oe_out [*6];
  endsequence
  chk_reset_values: assert property (
    $fell(rst_in) |-> !sda_oe_out && !update_strobe_out && regs == regs_rst)
    else $error("outputs not at reset values");
  chk_strobe_on_ack: assert property (
    update_strobe_out |-> $fell(sda_oe_out) && !scl_in)
    else $error("update strobe away from release of final ack");
  chk_regs_on_strobe: assert property (
    $changed(regs) |-> update_strobe_out || $past(soft_reset_out))
    else $error("register output moved without update strobe");
  chk_oe_scl_low: assert property (
    $changed(sda_oe_out) |-> !scl_in)
    else $error("data drive changed while clock high");
  chk_ack_holds: assert property (
    $rose(sda_oe_out) |=> s_held)
    else $error("data drive shorter than one bit");
  chk_stop_release: assert property (
    s_stop |=> (!sda_oe_out) [*8])
    else $error("data line driven after stop");
  chk_soft_clear: assert property (
    soft_reset_out |=> !soft_reset_out && regs == regs_rst)
    else $error("soft reset did not restore outputs");
  // a key write to the lock register resets at the release of its ack instead
  chk_gcall_in_ack: assert property (
    soft_reset_out && !update_strobe_out |-> scl_in && sda_oe_out)
    else $error("soft reset outside high phase of ack");
  chk_busy_discard: assert property (
    memory_operation_active_in && update_strobe_out |-> $stable(regs))
    else $error("register written while memory busy");
endmodule  // dpi_port_chk

bind dpi_port dpi_port_chk u_chk (
  .sys_clk_in, .rst_in, .scl_in, .sda_in, .memory_operation_active_in,
  .sda_oe_out, .wiper_setting_out, .spare_nonvolatile_byte_one_out,
  .spare_nonvolatile_byte_two_out, .output_shutdown_select_out,
  .reference_enable_out, .output_gain_select_out, .update_strobe_out,
  .soft_reset_out
);

// File: dpi_ctrl_model.sv
// two-wire bus controller model; data is open drain, only pulled low
`timescale 1ns/1ns
module dpi_ctrl_model (
  input wire sda_in,
  output reg scl_out,
  output reg sda_low_out
);
  initial begin
    scl_out = 1'h1;
    sda_low_out = 1'h0;
  end
  // start or repeated start: data falls while the clock is high
  task start;
    #100 sda_low_out = 1'h0;
    #100 scl_out = 1'h1;
    #200 sda_low_out = 1'h1;
    #200 scl_out = 1'h0;
  endtask
  // idle after stop also spaces the wiper updates apart
  task stop;
    #100 sda_low_out = 1'h1;
    #100 scl_out = 1'h1;
    #200 sda_low_out = 1'h0;
    #400;
  endtask
  // nine clocks msb first; a 1 releases data, r holds the sampled wire
  task xfer(input [8:0] d, output [8:0] r);
    integer i;
    for (i = 8; i >= 0; i = i - 1) begin
      #100 sda_low_out = ~d[i];
      #100 scl_out = 1'h1;
      #100 r[i] = sda_in;
      #100 scl_out = 1'h0;
    end
  endtask
endmodule  // dpi_ctrl_model

// File: tb_top.sv
// self-checking bench for the digipot two-wire target port
`timescale 1ns/1ns
module tb_top;
  localparam logic [3:0] pid = 4'h5;  // arbitrary identifier value
  localparam logic [23:0] reg_cmds = 24'h21_2526;
  logic sys_clk_in, rst_in, crc_user, crc_fact, busy, scl, sda_low, sda_oe;
  logic refen, rcl, sto;
  logic seen_rcl = 1'b0;
  logic seen_sto = 1'b0;
  logic [1:0] sel, shdn, gain;
  logic [7:0] wip, sp1, sp2, c;
  logic [8:0] r9;
  logic [15:0] v;
  int bad_count, n_compared, k;
  wire sda_w = !(sda_low || sda_oe);
  // the select pin may be strapped to either bus wire
  wire pin = sel[1] ? (sel[0] ? scl : sda_w) : sel[0];
  dpi_ctrl_model m (.sda_in(sda_w), .scl_out(scl), .sda_low_out(sda_low));
  dpi_port #(.PART_IDENTIFIER(pid), .SILICON_REVISION(2'h2)) dut (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_w),
    .address_select_pin_in(pin), .user_memory_checksum_error_in(crc_user),
    .factory_memory_checksum_error_in(crc_fact),
    .memory_operation_active_in(busy), .sda_out(), .sda_oe_out(sda_oe),
    .wiper_setting_out(wip), .spare_nonvolatile_byte_one_out(sp1),
    .spare_nonvolatile_byte_two_out(sp2), .output_shutdown_select_out(shdn),
    .reference_enable_out(refen), .output_gain_select_out(gain),
    .update_strobe_out(), .memory_recall_trigger_out(rcl),
    .memory_store_trigger_out(sto), .soft_reset_out()
  );
  // trigger outputs are one-cycle pulses, so remember that they happened
  always @(posedge sys_clk_in) begin
    if (rcl)
      seen_rcl <= 1'b1;
    if (sto)
      seen_sto <= 1'b1;
  end
  task chk(input string what, input [15:0] seen, input [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task wb(input [7:0] d, input ok);
    m.xfer({d, 1'h1}, r9);
    chk("ack", {15'h0000, ~r9[0]}, {15'h0000, ok});
  endtask
  task wr(input [6:0] a, input [7:0] cm, input [15:0] d, input ok);
    m.start;
    wb({a, 1'h0}, ok);
    wb(cm, ok);
    wb(d[15:8], ok);
    wb(d[7:0], ok);
    m.stop;
  endtask
  // cm[8] set means no command byte, so the last written register returns
  task rd(input [6:0] a, input [8:0] cm, output [15:0] d);
    m.start;
    if (!cm[8]) begin
      wb({a, 1'h0}, 1'h1);
      wb(cm[7:0], 1'h1);
      m.start;
    end
    wb({a, 1'h1}, 1'h1);
    m.xfer(9'h1fe, r9);
    d[15:8] = r9[8:1];
    m.xfer(9'h1ff, r9);
    d[7:0] = r9[8:1];
    m.stop;
  endtask
  task report_and_stop;
    if (bad_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    sys_clk_in = 1'h0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    #2000000;
    bad_count++;
    report_and_stop;
  end
  initial begin
    {rst_in, crc_user, crc_fact, busy, sel} = 6'h20;
    repeat (3) @(posedge sys_clk_in);
    #1 rst_in = 1'h0;
    repeat (10) @(posedge sys_clk_in);
    #1;
    chk("reset", {wip, 3'h0, shdn, refen, gain}, 16'h0010);
    for (k = 0; k < 4; k++) begin
      sel = k[1:0];
      wr({4'h9, 1'h0, sel}, 8'h21, {4'hf, 8'h3c ^ k[7:0], 4'hf}, 1'h1);
      wr({4'h9, 1'h0, sel + 2'h1}, 8'h21, 16'h0000, 1'h0);
      chk("wiper", {8'h00, wip}, {8'h00, 8'h3c ^ k[7:0]});
    end
    wr(7'h2b, 8'h21, 16'h0000, 1'h0);
    chk("wiper", {8'h00, wip}, 16'h003f);
    sel = 2'h0;
    for (k = 0; k < 3; k++) begin
      c = reg_cmds[8 * (2 - k) +: 8];
      wr(7'h48, c, {4'h0, 8'ha0 + k[7:0], 4'h0}, 1'h1);
      rd(7'h48, 9'h100, v);
      chk("last", {8'h00, v[11:4]}, {8'h00, 8'ha0 + k[7:0]});
      rd(7'h48, {1'h0, c}, v);
      chk("field", {8'h00, v[11:4]}, {8'h00, 8'ha0 + k[7:0]});
    end
    chk("spares", {wip, sp1}, 16'ha0a1);
    chk("spare2", {8'h00, sp2}, 16'h00a2);
    wr(7'h48, 8'hd1, 16'h01e5, 1'h1);
    rd(7'h48, 9'h0d1, v);
    chk("setup", v, 16'h01e5);
    chk("setup out", {11'h000, shdn, refen, gain}, 16'h0005);
    rd(7'h48, 9'h0d3, v);
    chk("lock", v, 16'h0008);
    {crc_user, crc_fact, busy} = 3'h4;
    rd(7'h48, 9'h0d0, v);
    chk("status", v & 16'he03f, {3'h4, 7'h00, pid, 2'h2});
    {crc_user, crc_fact, busy} = 3'h3;
    rd(7'h48, 9'h0d0, v);
    chk("status", v & 16'he03f, {3'h3, 7'h00, pid, 2'h2});
    // busy stays up across the whole write, so the data must be dropped
    wr(7'h48, 8'h21, 16'h0770, 1'h1);
    chk("wiper busy", {8'h00, wip}, 16'h00a0);
    {crc_user, crc_fact, busy} = 3'h0;
    wr(7'h48, 8'hd3, 16'h003a, 1'h1);
    chk("triggers", {14'h0000, seen_rcl, seen_sto}, 16'h0003);
    chk("key reset", {wip, 3'h0, shdn, refen, gain}, 16'h0010);
    sel = 2'h1;
    wr(7'h47, 8'h21, 16'h0550, 1'h1);
    chk("broadcast", {8'h00, wip}, 16'h0055);
    m.start;
    wb(8'h8f, 1'h0);
    m.stop;
    wb(8'h92, 1'h0);
    m.stop;
    m.start;
    wb(8'h00, 1'h1);
    wb(8'h06, 1'h1);
    m.stop;
    chk("gcall", {wip, 3'h0, shdn, refen, gain}, 16'h0010);
    report_and_stop;
  end
endmodule  // tb_top
